// ==== hdl/cpu_logic_selftest_controller.sv ====
// logic built-in self test controller for the processor core, with an axi4-lite slave
// Notes on behaviour
// R1 - software alone starts each run
// R2 - run all intervals or a chosen subset
// R3 - programmable slower core clock during test
// R4 - core isolated while test runs
// R5 - software saves core context beforehand
// R6 - core reset after each run
// R7 - rest of device keeps running
// R8 - self-test reset recorded as reset cause
// R9 - timeout counter watches run duration
// R10 - key plus fault insert forces fail when interval 0 is among those run
// R11 - global control bit 0 restarts test
// R12 - without key or insert, fail clears
// R13 - timeout ends run, sets status flag
// R14 - reset cause register holds latest cause
`timescale 1ns/10ps
`default_nettype none
module cpu_logic_selftest_controller (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic warm_reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] core_signature,
  output logic core_test_mode,
  output logic core_isolate,
  output logic core_reset_n,
  output logic [3:0] core_clock_divide,
  output logic [7:0] core_interval,
  output logic irq
);
  // register state
  logic [7:0] interval_start, next_interval_start;
  logic [7:0] interval_count, next_interval_count;
  logic [3:0] clock_divide, next_clock_divide;
  logic [3:0] check_key, next_check_key;
  logic fault_insert, next_fault_insert;
  logic [31:0] timeout_preload, next_timeout_preload;
  logic [3:0] global_status, next_global_status;
  logic [1:0] reset_cause, next_reset_cause;
  logic [2:0] irq_status, next_irq_status;
  logic [2:0] irq_enable, next_irq_enable;
  // bus state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic b_pending, next_b_pending;
  logic [1:0] b_code, next_b_code;
  logic r_pending, next_r_pending;
  logic [31:0] r_word, next_r_word;
  logic [1:0] r_code, next_r_code;
  // engine state
  selftest_pkg::test_state_e state, next_state;
  logic [7:0] interval, next_interval;
  logic [7:0] left, next_left;
  logic [15:0] step, next_step;
  logic [31:0] watchdog, next_watchdog;
  logic [31:0] signature, next_signature;
  logic [31:0] golden, next_golden;
  logic [7:0] reset_count, next_reset_count;
  logic forced_error, next_forced_error;
  logic warm_seen, next_warm_seen;
  logic write_fire;
  logic restart;
  selftest_pkg::test_events_s events;

  function automatic logic known_addr(input logic [7:0] addr);
    known_addr = (addr[1:0] == 2'h0) && (addr <= selftest_pkg::irq_clear_addr);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = result;
  endfunction

  assign awready = !aw_held && !b_pending;
  assign wready = !w_held && !b_pending;
  assign arready = !r_pending;
  assign bvalid = b_pending;
  assign bresp = b_code;
  assign rvalid = r_pending;
  assign rdata = r_word;
  assign rresp = r_code;
  assign write_fire = aw_held && w_held && !b_pending;
  // restart only from a software write; nothing starts a run by itself
  assign restart = write_fire && (aw_addr == selftest_pkg::global_control_addr) &&
                   w_strb[0] && w_data[selftest_pkg::restart_bit]; // R1 R11
  assign irq = |(irq_status & irq_enable);

  always_comb begin
    logic [31:0] merged;
    merged = merge(32'h0000_0000, w_data, w_strb);
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_b_pending = b_pending;
    next_b_code = b_code;
    next_r_pending = r_pending;
    next_r_word = r_word;
    next_r_code = r_code;
    next_interval_start = interval_start;
    next_interval_count = interval_count;
    next_clock_divide = clock_divide;
    next_check_key = check_key;
    next_fault_insert = fault_insert;
    next_timeout_preload = timeout_preload;
    next_irq_enable = irq_enable;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_b_pending = 1'b0;
    end
    if (write_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_b_pending = 1'b1;
      next_b_code = known_addr(aw_addr) ? selftest_pkg::axi_okay : selftest_pkg::axi_slverr;
      // configuration other than irq enable is frozen while a run is under way
      if (state == selftest_pkg::st_idle) begin
        unique case (aw_addr)
          selftest_pkg::interval_config_addr: begin
            merged = merge({16'h0000, interval_count, interval_start}, w_data, w_strb);
            next_interval_start = merged[7:0]; // R2
            next_interval_count = merged[15:8]; // R2
          end
          selftest_pkg::clock_divide_addr: begin
            merged = merge({28'h0000000, clock_divide}, w_data, w_strb);
            next_clock_divide = merged[3:0]; // R3
          end
          selftest_pkg::check_control_addr: begin
            merged = merge({27'h0, fault_insert, check_key}, w_data, w_strb);
            next_check_key = merged[3:0];
            next_fault_insert = merged[selftest_pkg::fault_insert_bit];
          end
          selftest_pkg::timeout_preload_addr: begin
            next_timeout_preload = merge(timeout_preload, w_data, w_strb);
          end
          selftest_pkg::irq_enable_addr: begin
            merged = merge({29'h0, irq_enable}, w_data, w_strb);
            next_irq_enable = merged[2:0];
          end
          default: begin
          end
        endcase
      end else if (aw_addr == selftest_pkg::irq_enable_addr) begin
        merged = merge({29'h0, irq_enable}, w_data, w_strb);
        next_irq_enable = merged[2:0];
      end
    end
    if (arvalid && arready) begin
      next_r_pending = 1'b1;
      next_r_code = known_addr(araddr) ? selftest_pkg::axi_okay : selftest_pkg::axi_slverr;
      unique case (araddr)
        selftest_pkg::interval_config_addr: next_r_word = {16'h0, interval_count, interval_start};
        selftest_pkg::clock_divide_addr: next_r_word = {28'h0, clock_divide};
        selftest_pkg::check_control_addr: next_r_word = {27'h0, fault_insert, check_key};
        selftest_pkg::global_status_addr: next_r_word = {28'h0, global_status};
        selftest_pkg::timeout_preload_addr: next_r_word = timeout_preload;
        selftest_pkg::reset_cause_addr: next_r_word = {30'h0, reset_cause}; // R8
        selftest_pkg::irq_status_addr: next_r_word = {29'h0, irq_status};
        selftest_pkg::irq_enable_addr: next_r_word = {29'h0, irq_enable};
        default: next_r_word = 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      next_r_pending = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_interval = interval;
    next_left = left;
    next_step = step;
    next_watchdog = watchdog;
    next_signature = signature;
    next_golden = golden;
    next_reset_count = reset_count;
    next_forced_error = forced_error;
    next_global_status = global_status;
    events = '{done: 1'b0, fail: 1'b0, timeout: 1'b0};
    unique case (state)
      selftest_pkg::st_idle: begin
        if (restart && interval_count != 8'h00) begin
          next_state = selftest_pkg::st_run;
          next_interval = interval_start; // R2
          next_left = interval_count; // R2
          next_step = 16'h0000;
          next_watchdog = timeout_preload; // R9
          next_signature = selftest_pkg::signature_seed;
          next_golden = selftest_pkg::signature_seed;
          next_forced_error = 1'b0;
          next_global_status = 4'h0;
          next_global_status[selftest_pkg::status_busy_bit] = 1'b1;
        end
      end
      selftest_pkg::st_run: begin
        // compacted core response against the reference built from the same seed
        next_signature = {signature[30:0], 1'b0} ^
                         (signature[31] ? selftest_pkg::signature_poly : 32'h0) ^ core_signature;
        next_golden = {golden[30:0], 1'b0} ^
                      (golden[31] ? selftest_pkg::signature_poly : 32'h0) ^ core_signature;
        if (interval == 8'h00 && check_key == selftest_pkg::check_key_unlock && fault_insert) begin
          next_forced_error = 1'b1; // R10 R12
        end
        next_watchdog = watchdog - 32'h1;
        if (watchdog == 32'h0) begin
          next_state = selftest_pkg::st_core_reset; // R13
          next_reset_count = selftest_pkg::core_reset_cycles;
          next_global_status[selftest_pkg::status_timeout_bit] = 1'b1; // R13
          next_global_status[selftest_pkg::status_fail_bit] = 1'b1;
          next_global_status[selftest_pkg::status_busy_bit] = 1'b0;
          events.timeout = 1'b1;
          events.fail = 1'b1;
        end else if (step == selftest_pkg::interval_length - 16'h1) begin
          next_step = 16'h0000;
          next_interval = interval + 8'h1;
          next_left = left - 8'h1;
          if (left == 8'h01) begin
            next_state = selftest_pkg::st_check;
          end
        end else begin
          next_step = step + 16'h1;
        end
      end
      selftest_pkg::st_check: begin
        next_state = selftest_pkg::st_core_reset; // R6
        next_reset_count = selftest_pkg::core_reset_cycles;
        next_global_status[selftest_pkg::status_done_bit] = 1'b1;
        next_global_status[selftest_pkg::status_busy_bit] = 1'b0;
        next_global_status[selftest_pkg::status_fail_bit] =
          forced_error || (signature != golden); // R10 R12
        events.done = 1'b1;
        events.fail = forced_error || (signature != golden);
      end
      selftest_pkg::st_core_reset: begin
        next_reset_count = reset_count - 8'h1;
        if (reset_count == 8'h01) begin
          next_state = selftest_pkg::st_idle;
        end
      end
      default: begin
        next_state = selftest_pkg::st_idle;
      end
    endcase
  end

  always_comb begin
    next_warm_seen = 1'b0;
    next_reset_cause = reset_cause;
    // a new cause replaces the old one so the latest reset is what software sees
    if (!warm_reset_n && warm_seen == 1'b0) begin
      next_reset_cause = 2'h0;
      next_reset_cause[selftest_pkg::cause_warm_bit] = 1'b1; // R14
    end
    if (state == selftest_pkg::st_core_reset && reset_count == 8'h01) begin
      next_reset_cause = 2'h0;
      next_reset_cause[selftest_pkg::cause_selftest_bit] = 1'b1; // R8 R14
    end
    next_warm_seen = !warm_reset_n;
    // set wins over a clear in the same cycle
    next_irq_status = irq_status;
    if (write_fire && aw_addr == selftest_pkg::irq_clear_addr && w_strb[0]) begin
      next_irq_status = irq_status & ~w_data[2:0];
    end
    next_irq_status = next_irq_status | {events.timeout, events.fail, events.done};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      b_pending <= 1'b0;
      b_code <= selftest_pkg::axi_okay;
      r_pending <= 1'b0;
      r_word <= 32'h0000_0000;
      r_code <= selftest_pkg::axi_okay;
      interval_start <= 8'h00;
      interval_count <= selftest_pkg::interval_count_reset;
      clock_divide <= selftest_pkg::clock_divide_reset;
      check_key <= 4'h0;
      fault_insert <= 1'b0;
      timeout_preload <= selftest_pkg::timeout_preload_reset;
      irq_enable <= 3'h0;
      irq_status <= 3'h0;
      reset_cause <= 2'h0;
      warm_seen <= 1'b0;
      state <= selftest_pkg::st_idle;
      interval <= 8'h00;
      left <= 8'h00;
      step <= 16'h0000;
      watchdog <= 32'h0000_0000;
      signature <= 32'h0000_0000;
      golden <= 32'h0000_0000;
      reset_count <= 8'h00;
      forced_error <= 1'b0;
      global_status <= 4'h0;
    end else if (clk_en) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      b_pending <= next_b_pending;
      b_code <= next_b_code;
      r_pending <= next_r_pending;
      r_word <= next_r_word;
      r_code <= next_r_code;
      interval_start <= next_interval_start;
      interval_count <= next_interval_count;
      clock_divide <= next_clock_divide;
      check_key <= next_check_key;
      fault_insert <= next_fault_insert;
      timeout_preload <= next_timeout_preload;
      irq_enable <= next_irq_enable;
      irq_status <= next_irq_status;
      reset_cause <= next_reset_cause;
      warm_seen <= next_warm_seen;
      state <= next_state;
      interval <= next_interval;
      left <= next_left;
      step <= next_step;
      watchdog <= next_watchdog;
      signature <= next_signature;
      golden <= next_golden;
      reset_count <= next_reset_count;
      forced_error <= next_forced_error;
      global_status <= next_global_status;
    end
  end

  // core-facing controls; only the core is touched, the rest of the device runs on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_test_mode <= 1'b0;
      core_isolate <= 1'b0;
      core_reset_n <= 1'b1;
      core_clock_divide <= 4'h0;
      core_interval <= 8'h00;
    end else if (clk_en) begin
      core_test_mode <= (next_state == selftest_pkg::st_run);
      core_isolate <= (next_state != selftest_pkg::st_idle); // R4 R7
      core_reset_n <= (next_state != selftest_pkg::st_core_reset); // R6 R7
      core_clock_divide <= (next_state == selftest_pkg::st_run) ? clock_divide : 4'h0; // R3
      core_interval <= next_interval;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/selftest_pkg.sv ====
// shared constants and types for the core self-test controller
package selftest_pkg;
  // byte addresses of the software registers
  localparam logic [7:0] global_control_addr = 8'h00;
  localparam logic [7:0] interval_config_addr = 8'h04;
  localparam logic [7:0] clock_divide_addr = 8'h08;
  localparam logic [7:0] check_control_addr = 8'h0C;
  localparam logic [7:0] global_status_addr = 8'h10;
  localparam logic [7:0] timeout_preload_addr = 8'h14;
  localparam logic [7:0] reset_cause_addr = 8'h18;
  localparam logic [7:0] irq_status_addr = 8'h1C;
  localparam logic [7:0] irq_enable_addr = 8'h20;
  localparam logic [7:0] irq_clear_addr = 8'h24;
  // field positions
  localparam int restart_bit = 0;
  localparam int check_key_lsb = 0;
  localparam int fault_insert_bit = 4;
  localparam int status_done_bit = 0;
  localparam int status_fail_bit = 1;
  localparam int status_timeout_bit = 2;
  localparam int status_busy_bit = 3;
  localparam int cause_selftest_bit = 0;
  localparam int cause_warm_bit = 1;
  // key value that unlocks fault insertion
  localparam logic [3:0] check_key_unlock = 4'hA;
  // reset values and timing
  localparam logic [7:0] interval_count_reset = 8'h01;
  localparam logic [3:0] clock_divide_reset = 4'h0;
  localparam logic [31:0] timeout_preload_reset = 32'h0000_1000;
  localparam logic [15:0] interval_length = 16'h0040;
  localparam logic [7:0] core_reset_cycles = 8'h10;
  localparam logic [31:0] signature_seed = 32'h0000_0001;
  localparam logic [31:0] signature_poly = 32'h04C1_1DB7;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_run = 3'b001,
    st_check = 3'b010,
    st_core_reset = 3'b011
  } test_state_e;

  typedef struct packed {
    logic done;
    logic fail;
    logic timeout;
  } test_events_s;
endpackage

// ==== tb/core_model.sv ====
// behavioural processor core answering the self-test scan
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_test_mode,
  input wire logic core_reset_n,
  input wire logic [3:0] core_clock_divide,
  output logic [31:0] core_signature
);
  logic [3:0] slow_cnt = 4'h0;
  logic [31:0] ctx = 32'h0000_0000;
  initial core_signature = 32'h1357_9BDF;
  always @(posedge aclk) begin
    if (!aresetn || !core_test_mode) begin
      slow_cnt <= 4'h0;
      core_signature <= ~core_signature; // not driving a result: no stable value
    end else if (slow_cnt >= core_clock_divide) begin
      slow_cnt <= 4'h0;
      core_signature <= {core_signature[30:0], ~(core_signature[31] ^ core_signature[21])};
    end else begin
      slow_cnt <= slow_cnt + 4'h1;
    end
    // state is scrambled by the scan, so software must save it first
    if (core_test_mode) ctx <= ctx ^ core_signature;
    if (!core_reset_n) ctx <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// ==== tb/cpu_logic_selftest_controller_tb_top.sv ====
// self-checking bench for the core self-test controller
`timescale 1ns/10ps
`default_nettype none
module cpu_logic_selftest_controller_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic warm_reset_n = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, core_test_mode, core_isolate, core_reset_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, core_signature;
  logic [3:0] core_clock_divide;
  logic [7:0] core_interval;
  logic [1:0] resp;
  int bad_count = 0;
  int samples_checked = 0;
  int mode_cnt = 0;
  cpu_logic_selftest_controller uut (.aclk, .aresetn, .clk_en, .warm_reset_n, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .core_signature, .core_test_mode, .core_isolate,
    .core_reset_n, .core_clock_divide, .core_interval, .irq);
  core_model core (.aclk, .aresetn, .core_test_mode, .core_reset_n, .core_clock_divide,
    .core_signature);
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) if (core_test_mode === 1'b1) mode_cnt <= mode_cnt + 1;
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // no local limit: a missing answer is caught by the watchdog
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid && bready; resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    logic ah, rh;
    rh = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready; rh = rvalid && rready; d = rdata; resp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp,
                           input logic [31:0] mask);
    logic [31:0] d;
    axi_read(a, d);
    check(what, exp, d & mask);
  endtask
  task automatic start_run;
    mode_cnt = 0;
    axi_write(selftest_pkg::global_control_addr, 32'h0000_0001);
    @(negedge aclk);
  endtask
  task automatic finish_run;
    // a run that never ends is left to the watchdog
    while (core_reset_n !== 1'b0) @(negedge aclk);
    while (core_reset_n !== 1'b1) @(negedge aclk);
  endtask
  task automatic t_reset_values;
    logic [31:0] d;
    reg_check("interval cfg", selftest_pkg::interval_config_addr, 32'h0000_0100, 32'hFFFF);
    reg_check("clock div", selftest_pkg::clock_divide_addr, 32'h0, 32'hF);
    reg_check("preload", selftest_pkg::timeout_preload_addr, 32'h0000_1000, 32'hFFFF_FFFF);
    reg_check("idle status", selftest_pkg::global_status_addr, 32'h0, 32'hF);
    axi_read(8'h28, d);
    check("unmapped resp", {30'h0, selftest_pkg::axi_slverr}, {30'h0, resp});
    check("unmapped data", 32'h0, d);
    $display("test reset_values done");
  endtask
  task automatic t_full_run;
    axi_write(selftest_pkg::interval_config_addr, 32'h0000_0200);
    axi_write(selftest_pkg::clock_divide_addr, 32'h0000_0003);
    axi_write(selftest_pkg::irq_enable_addr, 32'h0000_0001);
    start_run;
    check("isolated", 32'h1, {31'h0, core_isolate});
    check("slow clock", 32'h3, {28'h0, core_clock_divide});
    axi_write(selftest_pkg::clock_divide_addr, 32'h0000_0005);
    check("refused write resp", 32'h0, {30'h0, resp});
    reg_check("busy", selftest_pkg::global_status_addr, 32'h8, 32'h8);
    finish_run;
    check("run cycles", 32'd128, mode_cnt);
    reg_check("div kept", selftest_pkg::clock_divide_addr, 32'h3, 32'hF);
    reg_check("pass status", selftest_pkg::global_status_addr, 32'h1, 32'hF);
    reg_check("cause", selftest_pkg::reset_cause_addr, 32'h1, 32'h3);
    check("done irq", 32'h1, {31'h0, irq});
    axi_write(selftest_pkg::irq_clear_addr, 32'h0000_0007);
    @(negedge aclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    axi_write(selftest_pkg::clock_divide_addr, 32'h0000_0000);
    $display("test full_run done");
  endtask
  task automatic t_fault_insert;
    axi_write(selftest_pkg::interval_config_addr, 32'h0000_0100);
    axi_write(selftest_pkg::check_control_addr, 32'h0000_001A);
    start_run;
    finish_run;
    reg_check("forced fail", selftest_pkg::global_status_addr, 32'h2, 32'h2);
    axi_write(selftest_pkg::check_control_addr, 32'h0000_000A);
    start_run;
    finish_run;
    reg_check("no insert", selftest_pkg::global_status_addr, 32'h0, 32'h2);
    axi_write(selftest_pkg::check_control_addr, 32'h0000_0010);
    start_run;
    finish_run;
    reg_check("no key", selftest_pkg::global_status_addr, 32'h0, 32'h2);
    $display("test fault_insert done");
  endtask
  task automatic t_subset;
    axi_write(selftest_pkg::check_control_addr, 32'h0000_001A);
    axi_write(selftest_pkg::interval_config_addr, 32'h0000_0102);
    start_run;
    check("first interval", 32'h2, {24'h0, core_interval});
    finish_run;
    reg_check("zero skipped", selftest_pkg::global_status_addr, 32'h0, 32'h2);
    axi_write(selftest_pkg::check_control_addr, 32'h0000_0000);
    $display("test subset done");
  endtask
  task automatic t_timeout;
    axi_write(selftest_pkg::interval_config_addr, 32'h0000_0100);
    axi_write(selftest_pkg::timeout_preload_addr, 32'h0000_0020);
    axi_write(selftest_pkg::irq_enable_addr, 32'h0000_0000);
    start_run;
    // freeze mid-run: mode stays high, the watchdog must not count these ten edges
    @(posedge aclk);
    clk_en <= 1'b0;
    repeat (10) @(posedge aclk);
    clk_en <= 1'b1;
    finish_run;
    check("timeout cycles", 32'd43, mode_cnt);
    reg_check("timeout status", selftest_pkg::global_status_addr, 32'h6, 32'h6);
    check("masked irq", 32'h0, {31'h0, irq});
    reg_check("irq status", selftest_pkg::irq_status_addr, 32'h4, 32'h4);
    axi_write(selftest_pkg::irq_enable_addr, 32'h0000_0004);
    @(negedge aclk);
    check("timeout irq", 32'h1, {31'h0, irq});
    axi_write(selftest_pkg::irq_clear_addr, 32'h0000_0004);
    @(negedge aclk);
    check("irq low", 32'h0, {31'h0, irq});
    axi_write(selftest_pkg::timeout_preload_addr, 32'h0000_1000);
    $display("test timeout done");
  endtask
  task automatic t_warm_reset;
    @(posedge aclk);
    warm_reset_n <= 1'b0;
    @(posedge aclk);
    warm_reset_n <= 1'b1;
    reg_check("warm cause", selftest_pkg::reset_cause_addr, 32'h2, 32'h3);
    $display("test warm_reset done");
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("[FAIL] watchdog expected end seen hang");
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values;
    t_full_run;
    t_fault_insert;
    t_subset;
    t_timeout;
    t_warm_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ==== tb/selftest_props.sv ====
// port assertions for the core self-test controller
`timescale 1ns/10ps
`default_nettype none
module selftest_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic core_test_mode,
  input wire logic core_isolate,
  input wire logic core_reset_n,
  input wire logic [3:0] core_clock_divide,
  input wire logic [7:0] core_interval
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  // counts core reset cycles; cleared by bus reset as well
  always_comb begin
    next_low_cnt = (!aresetn || core_reset_n) ? 8'h00 : low_cnt + 8'h01;
  end
  always_ff @(posedge aclk) begin
    low_cnt <= next_low_cnt;
  end
  isolate_during_run_a: assert property (core_test_mode |-> core_isolate)
    else $error("core not isolated during test");
  core_reset_len_a: assert property ($rose(core_reset_n) && $past(aresetn) |->
    low_cnt == selftest_pkg::core_reset_cycles) else $error("core reset length wrong");
  reset_after_run_a: assert property ($fell(core_test_mode) && $past(aresetn) |->
    ##[1:3] !core_reset_n) else $error("no core reset after run");
  idle_after_reset_a: assert property ($rose(core_reset_n) && $past(aresetn) |->
    ##[0:1] !core_isolate) else $error("core still isolated after reset");
  start_by_write_a: assert property ($rose(core_test_mode) |-> bvalid)
    else $error("run started without a write");
  divide_idle_a: assert property (!core_isolate |-> core_clock_divide == 4'h0)
    else $error("slow clock outside test");
  divide_steady_a: assert property (core_test_mode && $past(core_test_mode) |->
    $stable(core_clock_divide)) else $error("divide changed in run");
  interval_step_a: assert property (core_test_mode && $past(core_test_mode) &&
    core_interval != $past(core_interval) |-> core_interval == $past(core_interval) + 8'h01)
    else $error("interval skipped");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  // both words are held one edge, the response is raised on the edge after
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write not answered");
  cover property ($rose(core_test_mode));
  cover property ($rose(core_reset_n));
  cover property (core_test_mode && core_clock_divide != 4'h0);
endmodule
bind cpu_logic_selftest_controller selftest_props u_props (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .core_test_mode, .core_isolate,
  .core_reset_n, .core_clock_divide, .core_interval);
`default_nettype wire
